// >>> core/cnt_pkg.sv
// Constants and types shared by the sixteen-bit counter design
package cnt_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 16;
  localparam int PSC_W  = 3;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] ADDR_GIRQ    = 8'h0B;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_FLG = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_CNT_LO  = 8'h0E;
  localparam logic [ADDR_W-1:0] ADDR_CNT_HI  = 8'h0F;
  localparam logic [ADDR_W-1:0] ADDR_CTRL    = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR = 8'h1E;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_EN  = 8'h8C;

  // ****************************************
  // Field positions, masks and reset values
  // ****************************************
  localparam int CTRL_RUN    = 0;
  localparam int CTRL_CS     = 1;
  localparam int CTRL_NOSYNC = 2;
  localparam int CTRL_PS_LO  = 4;
  localparam int CTRL_PS_HI  = 5;
  localparam int FLAG_OVF    = 0;
  localparam logic [DATA_W-1:0] CTRL_MASK  = 8'h3F;
  localparam logic [DATA_W-1:0] CTRL_RST   = 8'h00;
  localparam logic [DATA_W-1:0] PIE_MASK   = 8'hF7;
  localparam logic [DATA_W-1:0] FLAG_MASK  = 8'h01;
  localparam logic [DATA_W-1:0] BYTE_ZERO  = 8'h00;
  localparam logic [CNT_W-1:0]  CNT_ZERO   = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ONE    = 16'h0001;
  localparam logic [CNT_W-1:0]  CNT_ONES   = 16'hFFFF;
  localparam logic [PSC_W-1:0]  PSC_ZERO   = 3'h0;
  localparam logic [PSC_W-1:0]  PSC_ONE    = 3'h1;
  localparam logic [3:0]        MODE_TRIG  = 4'hB;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ARM_OFF       = 3'b001,
    ARM_WAIT_FALL = 3'b010,
    ARM_LIVE      = 3'b100
  } arm_state_t;
endpackage

// >>> core/pin_sync.sv
// Three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level_r
);
  logic s1_r, s2_r, s3_r;
  logic level_nxt;

  // Level changes only once stages two and three agree
  always_comb begin
    level_nxt = (s2_r == s3_r) ? s3_r : level_r;
  end

  // Shift chain and filtered level
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
    end else begin
      s1_r    <= pin;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      level_r <= level_nxt;
    end
  end
endmodule // pin_sync
`default_nettype wire

// >>> core/prescaler.sv
// Selectable 1:1, 1:2, 1:4, 1:8 prescaler with synchronous clear
`timescale 1ns/10ps
`default_nettype none
module prescaler
  import cnt_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       tick,
  input  wire logic       clear,
  input  wire logic [1:0] sel,
  output logic            out
);
  logic [PSC_W-1:0] cnt_r;
  logic [PSC_W-1:0] cnt_nxt;
  logic [PSC_W-1:0] mask;

  always_comb begin
    unique case (sel)
      2'b00: mask = 3'h0;
      2'b01: mask = 3'h1;
      2'b10: mask = 3'h3;
      2'b11: mask = 3'h7;
    endcase
    out     = tick && !clear && ((cnt_r & mask) == mask);
    cnt_nxt = cnt_r;
    if (clear) begin
      cnt_nxt = PSC_ZERO;
    end else if (tick) begin
      cnt_nxt = out ? PSC_ZERO : PSC_W'(cnt_r + PSC_ONE);
    end
  end

  // Count register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_r <= PSC_ZERO;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule // prescaler
`default_nettype wire

// >>> core/sixteen_bit_counter.sv
// Sixteen-bit counter with compare trigger clear, prescaler and registers
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
// Function
// - Compare mode 1011 trigger clears the 16-bit counter to zero.
// - Trigger clear never sets the overflow flag.
// - Trigger clear is not applied in asynchronous counter mode.
// - Counter byte write in the trigger cycle wins over the clear.
// - In trigger mode the compare value acts as period.
// - Counter bytes survive every reset; only the trigger clears them.
// - Power-on or brown-out reset loads control with zero.
// - Other resets leave the control register unchanged.
// - Any counter byte write clears the prescaler count.
// - Count is read and written as low and high byte registers.
// - Timer mode advances once per instruction cycle after prescaler.
// - External mode counts rising edges after a first falling edge.
// - Run enable bit lets the counter advance; clear holds it.
// - Asynchronous counter mode keeps counting and interrupting in sleep.
module sixteen_bit_counter
  import cnt_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              cold_rst_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rd_data_r,
  input  wire logic              ext_clk_pin,
  input  wire logic              sleep_mode,
  input  wire logic [3:0]        compare_mode_field,
  input  wire logic [DATA_W-1:0] compare_value_high,
  input  wire logic [DATA_W-1:0] compare_value_low,
  output logic                   special_event_r,
  output logic                   irq_r
);
  // ****************************************
  // Declarations
  // ****************************************
  logic [DATA_W-1:0] ctrl_r, ctrl_nxt;
  logic [DATA_W-1:0] girq_r, girq_nxt;
  logic [DATA_W-1:0] pie_r, pie_nxt;
  logic [DATA_W-1:0] flag_r, flag_nxt;
  logic [DATA_W-1:0] rd_data_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  arm_state_t        arm_r, arm_nxt;
  logic              ext_lvl, ext_prev_r;
  logic              irq_nxt, sev_nxt;
  logic              run, ext_mode, async_mode;
  logic              wr_lo, wr_hi, wr_any, wr_clr;
  logic              rise, fall, psc_tick, psc_out, inc, wrap, trig_hit;

  // ****************************************
  // Pin input and prescaler
  // ****************************************
  pin_sync u_sync (
    .clock   (clock),
    .rst_n   (rst_n),
    .pin     (ext_clk_pin),
    .level_r (ext_lvl)
  );

  prescaler u_psc (
    .clock (clock),
    .rst_n (rst_n),
    .tick  (psc_tick),
    .clear (wr_any),
    .sel   (ctrl_r[CTRL_PS_HI:CTRL_PS_LO]),
    .out   (psc_out)
  );

  // ****************************************
  // Decode and count events
  // ****************************************
  // Mode bits and strobes
  always_comb begin
    run        = ctrl_r[CTRL_RUN];
    ext_mode   = ctrl_r[CTRL_CS];
    async_mode = ext_mode && ctrl_r[CTRL_NOSYNC];
    wr_lo      = wr_en && (addr == ADDR_CNT_LO);
    wr_hi      = wr_en && (addr == ADDR_CNT_HI);
    wr_any     = wr_lo || wr_hi;
    wr_clr     = wr_en && (addr == ADDR_IRQ_CLR);
    rise       = ext_lvl && !ext_prev_r;
    fall       = !ext_lvl && ext_prev_r;
  end

  // arm on first falling edge after enable
  always_comb begin
    arm_nxt = arm_r;
    if (!run || !ext_mode) begin
      arm_nxt = ARM_OFF;
    end else begin
      unique case (arm_r)
        ARM_OFF:       arm_nxt = ARM_WAIT_FALL;
        ARM_WAIT_FALL: arm_nxt = fall ? ARM_LIVE : ARM_WAIT_FALL;
        ARM_LIVE:      arm_nxt = ARM_LIVE;
        default:       arm_nxt = ARM_OFF;
      endcase
    end
  end

  // clock is the instruction cycle; run gate
  always_comb begin
    psc_tick = run && (ext_mode ? (rise && (arm_r == ARM_LIVE)) : !sleep_mode);
    // asynchronous mode keeps counting in sleep
    inc      = psc_out && (async_mode || !sleep_mode);
    // no trigger clear in asynchronous mode
    trig_hit = (compare_mode_field == MODE_TRIG) && !async_mode &&
               (cnt_r == {compare_value_high, compare_value_low});
    // a wrap replaced by a clear or a write raises no flag
    wrap     = inc && !wr_any && !trig_hit && (cnt_r == CNT_ONES);
  end

  // ****************************************
  // Counter next value
  // ****************************************
  always_comb begin
    cnt_nxt = cnt_r;
    if (!rst_n) begin
      cnt_nxt = cnt_r;
    end else if (wr_any) begin
      if (wr_lo) begin
        cnt_nxt[7:0] = wr_data;
      end else begin
        cnt_nxt[15:8] = wr_data;
      end
    end else if (trig_hit) begin
      // trigger clears; compare acts as period
      cnt_nxt = CNT_ZERO;
    end else if (inc) begin
      cnt_nxt = CNT_W'(cnt_r + CNT_ONE);
    end
  end

  // No reset: the count holds across every reset
  always_ff @(posedge clock) begin
    cnt_r <= cnt_nxt;
  end

  // ****************************************
  // Registers, flags and read port
  // ****************************************
  always_comb begin
    ctrl_nxt   = ctrl_r;
    girq_nxt   = girq_r;
    pie_nxt    = pie_r;
    if (wr_en && (addr == ADDR_CTRL)) begin
      ctrl_nxt = wr_data & CTRL_MASK;
    end
    if (wr_en && (addr == ADDR_GIRQ)) begin
      girq_nxt = wr_data;
    end
    if (wr_en && (addr == ADDR_IRQ_EN)) begin
      pie_nxt = wr_data & PIE_MASK;
    end
    // wrap sets flag, set beats clear; trigger never sets it
    flag_nxt = flag_r & ~(wr_clr ? wr_data : BYTE_ZERO);
    flag_nxt[FLAG_OVF] = flag_nxt[FLAG_OVF] || wrap;
    flag_nxt = flag_nxt & FLAG_MASK;
    // enabled flag drives the level interrupt
    irq_nxt = flag_nxt[FLAG_OVF] && pie_nxt[FLAG_OVF];
    sev_nxt = trig_hit && !wr_any;
    rd_data_nxt = BYTE_ZERO;
    if (rd_en) begin
      unique case (addr)
        ADDR_GIRQ:    rd_data_nxt = girq_r;
        ADDR_IRQ_FLG: rd_data_nxt = flag_r;
        ADDR_CNT_LO: rd_data_nxt = cnt_r[7:0];
        ADDR_CNT_HI: rd_data_nxt = cnt_r[15:8];
        ADDR_CTRL:   rd_data_nxt = ctrl_r;
        ADDR_IRQ_EN: rd_data_nxt = pie_r;
        default:     rd_data_nxt = BYTE_ZERO;
      endcase
    end
  end

  // Register stage with two reset kinds
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      // power-on and brown-out zero control; others keep it
      ctrl_r          <= cold_rst_n ? ctrl_r : CTRL_RST;
      girq_r          <= BYTE_ZERO;
      pie_r           <= BYTE_ZERO;
      flag_r          <= BYTE_ZERO;
      arm_r           <= ARM_OFF;
      ext_prev_r      <= 1'b0;
      rd_data_r       <= BYTE_ZERO;
      irq_r           <= 1'b0;
      special_event_r <= 1'b0;
    end else begin
      ctrl_r          <= ctrl_nxt;
      girq_r          <= girq_nxt;
      pie_r           <= pie_nxt;
      flag_r          <= flag_nxt;
      arm_r           <= arm_nxt;
      ext_prev_r      <= ext_lvl;
      rd_data_r       <= rd_data_nxt;
      irq_r           <= irq_nxt;
      special_event_r <= sev_nxt;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_trig_clear;
    trig_hit && !wr_any;
  endsequence

  sequence s_first_step;
    inc && !wr_any && !trig_hit;
  endsequence

  trig_clear_a: assert property (s_trig_clear |=> cnt_r == CNT_ZERO)
    else $error("trigger did not clear counter");

  sev_pulse_a: assert property (s_trig_clear |=> special_event_r)
    else $error("special event pulse missing");

  trig_noflag_a: assert property (s_trig_clear and !flag_r[FLAG_OVF]
    |=> !flag_r[FLAG_OVF])
    else $error("trigger clear set overflow flag");

  async_hold_a: assert property (async_mode && !wr_any && !inc
    |=> $stable(cnt_r))
    else $error("counter changed in asynchronous mode without cause");

  write_wins_a: assert property (wr_lo && trig_hit
    |=> cnt_r[7:0] == $past(wr_data))
    else $error("trigger beat a counter write");

  // count restarts from zero after match
  period_restart_a: assert property (s_trig_clear ##1 s_first_step
    |=> cnt_r == CNT_ONE)
    else $error("count did not restart from zero");

  cnt_keep_a: assert property (disable iff (1'b0) !rst_n
    |=> $stable(cnt_r))
    else $error("reset changed counter");

  ctrl_por_a: assert property (disable iff (1'b0)
    !rst_n && !cold_rst_n |=> ctrl_r == CTRL_RST)
    else $error("control not zero after power-on reset");

  ctrl_keep_a: assert property (disable iff (1'b0)
    !rst_n && cold_rst_n |=> $stable(ctrl_r))
    else $error("control changed on warm reset");

  psc_clear_a: assert property (wr_any |=> u_psc.cnt_r == PSC_ZERO)
    else $error("prescaler not cleared by counter write");

  // high byte write lands in upper half
  byte_hi_a: assert property (wr_hi |=> cnt_r[15:8] == $past(wr_data))
    else $error("high byte write lost");

  // one step per cycle at 1:1
  timer_step_a: assert property (run && !ext_mode && !sleep_mode &&
    ctrl_r[CTRL_PS_HI:CTRL_PS_LO] == 2'b00 && !wr_any && !trig_hit
    |=> cnt_r == CNT_W'($past(cnt_r) + CNT_ONE))
    else $error("timer mode did not advance");

  // no counting before the falling edge
  arm_gate_a: assert property (ext_mode && arm_r != ARM_LIVE |-> !psc_tick)
    else $error("external edge counted before arming");

  run_hold_a: assert property (!run && !wr_any && !trig_hit
    |=> $stable(cnt_r))
    else $error("stopped counter moved");

  sleep_run_a: assert property (async_mode && sleep_mode && inc && !wr_any
    |=> cnt_r == CNT_W'($past(cnt_r) + CNT_ONE))
    else $error("asynchronous counter stalled in sleep");

  // flag rises only on wrap, interrupt follows
  flag_cause_a: assert property ($rose(flag_r[FLAG_OVF]) |-> $past(wrap))
    else $error("overflow flag set without wrap");
  irq_follow_a: assert property (flag_r[FLAG_OVF] && pie_r[FLAG_OVF]
    && !wr_en |-> irq_r)
    else $error("enabled flag did not raise interrupt");
endmodule // sixteen_bit_counter
`default_nettype wire

// >>> bench/cmp_model.sv
// Behavioural compare unit that holds the mode and the compare value
`timescale 1ns/10ps
`default_nettype none
module cmp_model (
  input  wire logic        clock,
  input  wire logic        load,
  input  wire logic [3:0]  mode_in,
  input  wire logic [15:0] val_in,
  // Idle in a non-trigger mode until the bench loads a setting
  output var  logic [3:0]  compare_mode_field = 4'h0,
  output var  logic [7:0]  compare_value_high = 8'h00,
  output var  logic [7:0]  compare_value_low  = 8'h00
);

  always @(posedge clock) begin
    if (load) begin
      compare_mode_field <= mode_in;
      compare_value_high <= val_in[15:8];
      compare_value_low  <= val_in[7:0];
    end
  end
endmodule // cmp_model
`default_nettype wire

// >>> bench/sixteen_bit_counter_tb_top.sv
// Self-checking bench for the sixteen-bit counter block
`timescale 1ns/10ps
`default_nettype none
module sixteen_bit_counter_tb_top import cnt_pkg::*;;
  logic              clock = 1'b0;
  logic              rst_n = 1'b0;
  logic              cold_rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wr_data = 8'h00;
  logic              wr_en = 1'b0;
  logic              rd_en = 1'b0;
  logic              ext_clk_pin = 1'b0;
  logic              sleep_mode = 1'b0;
  logic              load = 1'b0;
  logic [3:0]        mode_in = 4'h0;
  logic [CNT_W-1:0]  val_in = 16'h0000;
  logic [DATA_W-1:0] rd_data_r;
  logic [3:0]        cmf;
  logic [DATA_W-1:0] cvh;
  logic [DATA_W-1:0] cvl;
  logic              special_event_r;
  logic              irq_r;
  int                fail_count = 0;
  int                checked = 0;
  logic [CNT_W-1:0]  v;
  int                n;

  // 100 ns clock
  always #50 clock = ~clock;

  sixteen_bit_counter dut (
    .clock(clock), .rst_n(rst_n), .cold_rst_n(cold_rst_n),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data_r(rd_data_r), .ext_clk_pin(ext_clk_pin), .sleep_mode(sleep_mode),
    .compare_mode_field(cmf), .compare_value_high(cvh), .compare_value_low(cvl),
    .special_event_r(special_event_r), .irq_r(irq_r)
  );

  cmp_model partner (
    .clock(clock), .load(load), .mode_in(mode_in), .val_in(val_in),
    .compare_mode_field(cmf), .compare_value_high(cvh), .compare_value_low(cvl)
  );

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    @(negedge clock);
    d = rd_data_r;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask

  task automatic setcnt(input logic [15:0] c);
    wr(ADDR_CNT_HI, c[15:8]);
    wr(ADDR_CNT_LO, c[7:0]);
  endtask

  task automatic cntc(input logic [15:0] e);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(ADDR_CNT_LO, lo);
    rd(ADDR_CNT_HI, hi);
    chk({hi, lo}, e);
  endtask

  // Runs the counter for k+2 counting edges, then stops it
  task automatic run(input logic [7:0] c, input int k);
    wr(ADDR_CTRL, c | 8'h01);
    repeat (k) @(posedge clock);
    wr(ADDR_CTRL, c);
  endtask

  task automatic cmp(input logic [3:0] m, input logic [15:0] c);
    @(posedge clock);
    load <= 1'b1;
    mode_in <= m;
    val_in <= c;
    @(posedge clock);
    load <= 1'b0;
  endtask

  task automatic pulses(input int p);
    repeat (p) begin
      ext_clk_pin <= 1'b0;
      repeat (6) @(posedge clock);
      ext_clk_pin <= 1'b1;
      repeat (6) @(posedge clock);
    end
  endtask

  task automatic do_rst(input logic por);
    @(posedge clock);
    rst_n <= 1'b0;
    cold_rst_n <= por;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    cold_rst_n <= 1'b1;
  endtask

  task automatic stop_test;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ****************************************
  // Test sequence and watchdog
  // ****************************************
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    stop_test();
  end

  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    cold_rst_n <= 1'b1;
    rdc(ADDR_CTRL, 8'h00);
    rdc(ADDR_IRQ_FLG, 8'h00);
    rdc(ADDR_IRQ_EN, 8'h00);
    wr(ADDR_GIRQ, 8'hA5);
    rdc(ADDR_GIRQ, 8'hA5);
    wr(ADDR_IRQ_FLG, 8'hFF);
    rdc(ADDR_IRQ_FLG, 8'h00);
    rdc(8'h55, 8'h00);
    wr(ADDR_CTRL, 8'h3A);
    setcnt(16'h1234);
    do_rst(1'b1);
    rdc(ADDR_CTRL, 8'h3A);
    cntc(16'h1234);
    do_rst(1'b0);
    rdc(ADDR_CTRL, 8'h00);
    cntc(16'h1234);
    $display("reset test done");
    setcnt(16'h0000);
    wr(ADDR_CTRL, 8'h03);
    ext_clk_pin <= 1'b1;
    repeat (8) @(posedge clock);
    pulses(3);
    wr(ADDR_CTRL, 8'h02);
    cntc(16'h0003);
    @(posedge clock);
    sleep_mode <= 1'b1;
    run(8'h00, 14);
    cntc(16'h0003);
    wr(ADDR_CTRL, 8'h07);
    pulses(2);
    wr(ADDR_CTRL, 8'h06);
    cntc(16'h0005);
    @(posedge clock);
    sleep_mode <= 1'b0;
    $display("external test done");
    cmp(MODE_TRIG, 16'h0005);
    repeat (4) @(posedge clock);
    cntc(16'h0005);
    wr(ADDR_CTRL, 8'h00);
    cntc(16'h0000);
    rdc(ADDR_IRQ_FLG, 8'h00);
    wr(ADDR_CTRL, 8'h01);
    n = 0;
    while (special_event_r !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (special_event_r !== 1'b1 && n < 20);
    chk(16'(n), 16'h0006);
    wr(ADDR_CTRL, 8'h00);
    cmp(MODE_TRIG, 16'h0000);
    setcnt(16'h0000);
    wr(ADDR_CNT_LO, 8'h33);
    cntc(16'h0033);
    cmp(4'h0, 16'h0000);
    $display("trigger test done");
    for (int s = 0; s < 4; s++) begin
      setcnt(16'h0000);
      run(8'(s << 4), 62);
      cntc(16'h0040 >> s);
    end
    run(8'h30, 2);
    setcnt(16'h0000);
    run(8'h30, 10);
    cntc(16'h0001);
    $display("prescaler test done");
    setcnt(16'hFFFE);
    run(8'h00, 2);
    cntc(16'h0002);
    chk({15'h0000, irq_r}, 16'h0000);
    rdc(ADDR_IRQ_FLG, 8'h01);
    wr(ADDR_IRQ_EN, 8'h01);
    repeat (2) @(negedge clock);
    chk({15'h0000, irq_r}, 16'h0001);
    wr(ADDR_IRQ_CLR, 8'h01);
    repeat (2) @(negedge clock);
    chk({15'h0000, irq_r}, 16'h0000);
    rdc(ADDR_IRQ_FLG, 8'h00);
    $display("overflow test done");
    stop_test();
  end
endmodule // sixteen_bit_counter_tb_top
`default_nettype wire
